/* logic/tpg_pkg.sv */
// constants of the three-port general-purpose I/O block
package tpg_pkg;

    // ****************************************************************
    // bus geometry
    // ****************************************************************
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned IDX_W  = 6;
    localparam int unsigned PORT_W = 8;

    // ****************************************************************
    // register indices; byte address is four times the index
    // ****************************************************************
    localparam logic [5:0] IDX_PORT_A   = 6'h00;
    localparam logic [5:0] IDX_PORT_B   = 6'h01;
    localparam logic [5:0] IDX_PORT_C   = 6'h02;
    localparam logic [5:0] IDX_DIR_A    = 6'h04;
    localparam logic [5:0] IDX_DIR_B    = 6'h05;
    localparam logic [5:0] IDX_DIR_C    = 6'h06;
    localparam logic [5:0] IDX_LED_A    = 6'h07;
    localparam logic [5:0] IDX_FUNC     = 6'h08;
    localparam logic [5:0] IDX_ADC_SEL  = 6'h09;
    localparam logic [5:0] IDX_TMR_SEL  = 6'h0A;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0] DIR_RESET     = 8'h00;
    localparam logic [7:0] LED_RESET     = 8'h00;
    localparam logic [4:0] FUNC_RESET    = 5'h00;
    localparam logic [4:0] ADC_SEL_RESET = 5'h1F;
    localparam logic [7:0] TMR_SEL_RESET = 8'h00;

    // ****************************************************************
    // function enable register fields and converter select width and pin count
    // ****************************************************************
    localparam int unsigned FUNC_W         = 5;
    localparam int unsigned FB_IIC         = 0;
    localparam int unsigned FB_SCI         = 1;
    localparam int unsigned FB_SPI         = 2;
    localparam int unsigned FB_IRSCI       = 3;
    localparam int unsigned FB_PULLUP_DIS  = 4;
    localparam int unsigned ADC_W          = 5;
    localparam logic [4:0]  ADC_PIN_COUNT  = 5'h08;

    // ****************************************************************
    // bus answer states
    // ****************************************************************
    typedef enum logic {
        BUS_IDLE,
        BUS_ANSWER
    } tpg_bus_state_e;

endpackage

/* logic/tpg_reg_if.sv */
// register access carrier between bus slave and port core
`timescale 1ns/1ns
interface tpg_reg_if;
    logic [5:0] index;
    logic [7:0] wdata;
    logic       wr_stb;
    logic [7:0] rdata;
    logic       hit;

    modport slave (output index, output wdata, output wr_stb, input rdata, input hit);
    modport core  (input index, input wdata, input wr_stb, output rdata, output hit);
endinterface

/* logic/tpg_bus_slave.sv */
// avalon-mm slave front end with one wait state
`timescale 1ns/1ns
module tpg_bus_slave (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // avalon-mm
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // core side
    tpg_reg_if.slave         rif
);

    tpg_pkg::tpg_bus_state_e state;
    tpg_pkg::tpg_bus_state_e next_state;
    logic                    req;

    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & (state != tpg_pkg::BUS_ANSWER);
    assign rif.index       = avs_address[7:2];
    assign rif.wdata       = avs_writedata[7:0];
    // only the low lane holds data; a write without it is dropped
    assign rif.wr_stb      = avs_write & avs_byteenable[0] & (state == tpg_pkg::BUS_ANSWER);

    always_comb begin
        case (state)
            tpg_pkg::BUS_IDLE:   next_state = req ? tpg_pkg::BUS_ANSWER : tpg_pkg::BUS_IDLE;
            tpg_pkg::BUS_ANSWER: next_state = tpg_pkg::BUS_IDLE;
            default:             next_state = tpg_pkg::BUS_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= tpg_pkg::BUS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // read data captured on entry to the answer cycle, held until the next read
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && state == tpg_pkg::BUS_IDLE) begin
            avs_readdata <= {24'h000000, rif.hit ? rif.rdata : 8'h00};
        end
    end

endmodule

/* logic/tpg_gpio.sv */
// three-port general-purpose I/O core with peripheral pin sharing
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ns

// Notes on behaviour
// - each port has an 8-bit data latch that reset leaves alone
// - direction 1 drives the latched value, direction 0 leaves the pin undriven
// - reset clears every direction bit, so all pins start as inputs
// - port A data read returns the latch for output pins
// - port data read returns the pin level for input pins
// - data writes always reach the latch; input pins still read the pin
// - port B data read selects latch or pin per direction bit
// - port C data read selects latch or pin per direction bit
// - converter channel select hands its port A pin to the converter
// - led enable gives high-sink drive only while the pin is an output
// - iic enable gives port B pins 0 and 1 to the iic module
// - serial enable gives port B pins 2 and 3 to the serial interface
// - timer edge/level selects give port B pins 4 to 7 to timers
// - port B pins 0 to 3 only ever pull low when driving
// - port C pin 0 always feeds the interrupt; pullup off when disabled
// - spi enable gives port C pins 2 to 5 to the spi module
// - infrared serial enable gives port C pins 6 and 7 to it
module tpg_gpio (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // avalon-mm register bus
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // port A pins
    input  wire logic [7:0]  port_a_in,
    output logic      [7:0]  port_a_out,
    output logic      [7:0]  port_a_oe,
    output logic      [7:0]  port_a_led_sink,
    output logic      [7:0]  port_a_analog_sel,
    // port B pins
    input  wire logic [7:0]  port_b_in,
    output logic      [7:0]  port_b_out,
    output logic      [7:0]  port_b_oe,
    // port C pins
    input  wire logic [7:0]  port_c_in,
    output logic      [7:0]  port_c_out,
    output logic      [7:0]  port_c_oe,
    output logic             port_c0_pullup_en,
    // iic module
    input  wire logic        iic_sda_pull_low,
    input  wire logic        iic_scl_pull_low,
    output logic             iic_sda_in,
    output logic             iic_scl_in,
    // serial interface
    input  wire logic        sci_txd,
    output logic             sci_rxd,
    // timer channels, pins B4 to B7
    input  wire logic [3:0]  tmr_ch_out,
    input  wire logic [3:0]  tmr_ch_oe,
    output logic      [3:0]  tmr_ch_in,
    // spi, index 0 miso, 1 mosi, 2 ss, 3 spsck
    input  wire logic [3:0]  spi_out,
    input  wire logic [3:0]  spi_oe,
    output logic      [3:0]  spi_in,
    // infrared serial interface
    input  wire logic        infrared_transmit_line,
    output logic             infrared_receive_line,
    // external interrupt feed
    output logic             second_external_interrupt
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [7:0] read_sel(input logic [7:0] dir,
                                            input logic [7:0] latch,
                                            input logic [7:0] pin);
        read_sel = (dir & latch) | (~dir & pin);
    endfunction

    function automatic logic [7:0] adc_onehot(input logic [4:0] chan);
        adc_onehot = (chan < tpg_pkg::ADC_PIN_COUNT) ? (8'h01 << chan[2:0]) : 8'h00;
    endfunction

    // ****************************************************************
    // registers
    // ****************************************************************
    tpg_reg_if rif ();

    logic [7:0] first_port_latch;
    logic [7:0] second_port_latch;
    logic [7:0] third_port_latch;
    logic [7:0] first_port_direction;
    logic [7:0] second_port_direction;
    logic [7:0] third_port_direction;
    logic [7:0] led_sink_enable;
    logic [4:0] periph_func;
    logic [4:0] converter_channel_select;
    logic [7:0] timer_edge_level_select;

    logic wr_pa;
    logic wr_pb;
    logic wr_pc;
    logic wr_da;
    logic wr_db;
    logic wr_dc;
    logic wr_led;
    logic wr_func;
    logic wr_adc;
    logic wr_tmr;

    tpg_bus_slave u_slave (
        .sys_clk         (sys_clk),
        .reset_n         (reset_n),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .rif             (rif)
    );

    assign wr_pa   = rif.wr_stb & (rif.index == tpg_pkg::IDX_PORT_A);
    assign wr_pb   = rif.wr_stb & (rif.index == tpg_pkg::IDX_PORT_B);
    assign wr_pc   = rif.wr_stb & (rif.index == tpg_pkg::IDX_PORT_C);
    assign wr_da   = rif.wr_stb & (rif.index == tpg_pkg::IDX_DIR_A);
    assign wr_db   = rif.wr_stb & (rif.index == tpg_pkg::IDX_DIR_B);
    assign wr_dc   = rif.wr_stb & (rif.index == tpg_pkg::IDX_DIR_C);
    assign wr_led  = rif.wr_stb & (rif.index == tpg_pkg::IDX_LED_A);
    assign wr_func = rif.wr_stb & (rif.index == tpg_pkg::IDX_FUNC);
    assign wr_adc  = rif.wr_stb & (rif.index == tpg_pkg::IDX_ADC_SEL);
    assign wr_tmr  = rif.wr_stb & (rif.index == tpg_pkg::IDX_TMR_SEL);

    always_ff @(posedge sys_clk) begin
        if (wr_pa) begin
            first_port_latch <= rif.wdata;
        end
        if (wr_pb) begin
            second_port_latch <= rif.wdata;
        end
        if (wr_pc) begin
            third_port_latch <= rif.wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            first_port_direction  <= tpg_pkg::DIR_RESET;
            second_port_direction <= tpg_pkg::DIR_RESET;
            third_port_direction  <= tpg_pkg::DIR_RESET;
        end else begin
            if (wr_da) begin
                first_port_direction <= rif.wdata;
            end
            if (wr_db) begin
                second_port_direction <= rif.wdata;
            end
            if (wr_dc) begin
                third_port_direction <= rif.wdata;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            led_sink_enable          <= tpg_pkg::LED_RESET;
            periph_func              <= tpg_pkg::FUNC_RESET;
            converter_channel_select <= tpg_pkg::ADC_SEL_RESET;
            timer_edge_level_select  <= tpg_pkg::TMR_SEL_RESET;
        end else begin
            if (wr_led) begin
                led_sink_enable <= rif.wdata;
            end
            if (wr_func) begin
                periph_func <= rif.wdata[4:0];
            end
            if (wr_adc) begin
                converter_channel_select <= rif.wdata[4:0];
            end
            if (wr_tmr) begin
                timer_edge_level_select <= rif.wdata;
            end
        end
    end

    // ****************************************************************
    // read selection
    // ****************************************************************
    // pin levels are read as presented; an analog pin may read either way
    always_comb begin
        rif.hit = 1'b1;
        case (rif.index)
            tpg_pkg::IDX_PORT_A: rif.rdata = read_sel(first_port_direction,
                                                      first_port_latch, port_a_in);
            tpg_pkg::IDX_PORT_B: rif.rdata = read_sel(second_port_direction,
                                                      second_port_latch, port_b_in);
            tpg_pkg::IDX_PORT_C: rif.rdata = read_sel(third_port_direction,
                                                      third_port_latch, port_c_in);
            tpg_pkg::IDX_DIR_A:   rif.rdata = first_port_direction;
            tpg_pkg::IDX_DIR_B:   rif.rdata = second_port_direction;
            tpg_pkg::IDX_DIR_C:   rif.rdata = third_port_direction;
            tpg_pkg::IDX_LED_A:   rif.rdata = led_sink_enable;
            tpg_pkg::IDX_FUNC:    rif.rdata = {3'h0, periph_func};
            tpg_pkg::IDX_ADC_SEL: rif.rdata = {3'h0, converter_channel_select};
            tpg_pkg::IDX_TMR_SEL: rif.rdata = timer_edge_level_select;
            default: begin
                rif.rdata = 8'h00;
                rif.hit   = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // pin ownership
    // ****************************************************************
    logic [7:0] adc_own;
    logic [3:0] tmr_own;
    logic       iic_on;
    logic       sci_on;
    logic       spi_on;
    logic       irs_on;

    assign adc_own = adc_onehot(converter_channel_select);
    // any nonzero select pair claims the pin
    assign tmr_own = {|timer_edge_level_select[7:6], |timer_edge_level_select[5:4],
                      |timer_edge_level_select[3:2], |timer_edge_level_select[1:0]};
    assign iic_on  = periph_func[tpg_pkg::FB_IIC];
    assign sci_on  = periph_func[tpg_pkg::FB_SCI];
    assign spi_on  = periph_func[tpg_pkg::FB_SPI];
    assign irs_on  = periph_func[tpg_pkg::FB_IRSCI];

    logic [7:0] next_a_out;
    logic [7:0] next_a_oe;
    logic [7:0] next_a_led;
    logic [7:0] next_b_out;
    logic [7:0] next_b_oe;
    logic [7:0] next_c_out;
    logic [7:0] next_c_oe;

    assign next_a_out = first_port_latch;
    assign next_a_oe  = first_port_direction & ~adc_own;
    // high sink only on a driven output
    assign next_a_led = led_sink_enable & next_a_oe;

    always_comb begin
        // general purpose, low nibble open drain
        next_b_out = {second_port_latch[7:4], 4'h0};
        next_b_oe  = {second_port_direction[7:4],
                      second_port_direction[3:0] & ~second_port_latch[3:0]};
        if (iic_on) begin
            next_b_oe[0] = iic_sda_pull_low;
            next_b_oe[1] = iic_scl_pull_low;
        end
        // transmit pulls low, receive stays undriven
        if (sci_on) begin
            next_b_oe[2] = ~sci_txd;
            next_b_oe[3] = 1'b0;
        end
        // timer channels drive B4 to B7
        for (int k = 0; k < 4; k++) begin
            if (tmr_own[k]) begin
                next_b_out[4 + k] = tmr_ch_out[k];
                next_b_oe[4 + k]  = tmr_ch_oe[k];
            end
        end
    end

    always_comb begin
        next_c_out = third_port_latch;
        next_c_oe  = third_port_direction;
        if (spi_on) begin
            next_c_out[5:2] = spi_out;
            next_c_oe[5:2]  = spi_oe;
        end
        // infrared transmit on C6, receive on C7
        if (irs_on) begin
            next_c_out[6] = infrared_transmit_line;
            next_c_oe[6]  = 1'b1;
            next_c_oe[7]  = 1'b0;
        end
    end

    // ****************************************************************
    // output flops
    // ****************************************************************
    // one cycle of pin latency buys glitch-free outputs from flops
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            port_a_out        <= 8'h00;
            port_a_oe         <= 8'h00;
            port_a_led_sink   <= 8'h00;
            port_a_analog_sel <= 8'h00;
            port_b_out        <= 8'h00;
            port_b_oe         <= 8'h00;
            port_c_out        <= 8'h00;
            port_c_oe         <= 8'h00;
        end else begin
            port_a_out        <= next_a_out;
            port_a_oe         <= next_a_oe;
            port_a_led_sink   <= next_a_led;
            port_a_analog_sel <= adc_own;
            port_b_out        <= next_b_out;
            port_b_oe         <= next_b_oe;
            port_c_out        <= next_c_out;
            port_c_oe         <= next_c_oe;
        end
    end

    // pin levels go to peripherals whether or not they own the pin
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            iic_sda_in                <= 1'b1;
            iic_scl_in                <= 1'b1;
            sci_rxd                   <= 1'b1;
            tmr_ch_in                 <= 4'h0;
            spi_in                    <= 4'h0;
            infrared_receive_line     <= 1'b1;
            second_external_interrupt <= 1'b1;
            port_c0_pullup_en         <= 1'b1;
        end else begin
            iic_sda_in                <= port_b_in[0];
            iic_scl_in                <= port_b_in[1];
            sci_rxd                   <= port_b_in[3];
            tmr_ch_in                 <= port_b_in[7:4];
            spi_in                    <= port_c_in[5:2];
            infrared_receive_line     <= port_c_in[7];
            second_external_interrupt <= port_c_in[0];
            port_c0_pullup_en         <= ~periph_func[tpg_pkg::FB_PULLUP_DIS];
        end
    end

endmodule

/* tb/tpg_pin_model.sv */
// pins and outside circuits of the three ports
`timescale 1ns/1ns
module tpg_pin_model (
    // design pin drivers, index 0 port A, 1 port B, 2 port C
    input  wire logic [2:0][7:0] drv_level,
    input  wire logic [2:0][7:0] drv_en,
    // level set by outside circuits on undriven pins
    input  wire logic [2:0][7:0] outside_level,
    // resolved pin levels
    output logic      [2:0][7:0] pin_level
);
    // enabled buffers show their value, disabled ones leave the pin to outside
    assign pin_level[0] = (drv_en[0] & drv_level[0]) | (~drv_en[0] & outside_level[0]);
    // port B pins 3..0 can only pull low, the pullup gives the high
    assign pin_level[1] = (drv_en[1] & drv_level[1] & 8'hF0) | (~drv_en[1] & outside_level[1]);
    assign pin_level[2] = (drv_en[2] & drv_level[2]) | (~drv_en[2] & outside_level[2]);
endmodule

/* tb/tpg_gpio_checker.sv */
// pin-level assertions of the three-port gpio block
`timescale 1ns/1ns
module tpg_gpio_checker (
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       reset_n,
    // pins
    input wire logic [7:0] port_a_oe,
    input wire logic [7:0] port_a_led_sink,
    input wire logic [7:0] port_a_analog_sel,
    input wire logic [7:0] port_b_in,
    input wire logic [7:0] port_b_out,
    input wire logic [7:0] port_c_in,
    // peripheral feeds
    input wire logic       iic_sda_in,
    input wire logic       iic_scl_in,
    input wire logic       sci_rxd,
    input wire logic [3:0] tmr_ch_in,
    input wire logic [3:0] spi_in,
    input wire logic       infrared_receive_line,
    input wire logic       second_external_interrupt
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_led_needs_out: assert property ((port_a_led_sink & ~port_a_oe) == 8'h00)
        else $error("led drive on a pin that is not an output");
    a_analog_no_drive: assert property ((port_a_analog_sel & port_a_oe) == 8'h00)
        else $error("port drives a converter pin");
    a_analog_one_pin: assert property ($onehot0(port_a_analog_sel))
        else $error("more than one converter pin");
    a_b_low_only: assert property (port_b_out[3:0] == 4'h0)
        else $error("open-drain pin driven high");
    a_irq_follows_pin: assert property ($past(reset_n) |->
        second_external_interrupt == $past(port_c_in[0])) else $error("irq feed lost pin");
    a_iic_sees_pins: assert property ($past(reset_n) |->
        {iic_scl_in, iic_sda_in} == $past(port_b_in[1:0])) else $error("iic inputs lost pins");
    a_sci_sees_pin: assert property ($past(reset_n) |->
        sci_rxd == $past(port_b_in[3])) else $error("serial receive lost pin");
    a_timer_sees_pins: assert property ($past(reset_n) |->
        tmr_ch_in == $past(port_b_in[7:4])) else $error("timer inputs lost pins");
    a_spi_sees_pins: assert property ($past(reset_n) |->
        spi_in == $past(port_c_in[5:2])) else $error("spi inputs lost pins");
    a_ir_sees_pin: assert property ($past(reset_n) |->
        infrared_receive_line == $past(port_c_in[7])) else $error("infrared receive lost pin");
endmodule

/* tb/testbench.sv */
// self-checking bench for the three-port gpio block
`timescale 1ns/1ns
module testbench;
    logic            sys_clk = 1'b0;
    logic            reset_n = 1'b0;
    logic [7:0]      avs_address = 8'h00;
    logic            avs_read = 1'b0;
    logic            avs_write = 1'b0;
    logic [31:0]     avs_writedata = 32'h0;
    logic [31:0]     avs_readdata;
    logic            avs_waitrequest;
    logic [2:0][7:0] pin_x;
    logic [2:0][7:0] out_x;
    logic [2:0][7:0] oe_x;
    logic [2:0][7:0] ext_x = {8'h96, 8'h96, 8'h96};
    logic [7:0]      led;
    logic [7:0]      ana;
    logic [3:0]      tmr_out = 4'h0;
    logic [3:0]      tmr_oe = 4'h0;
    logic [3:0]      spi_out = 4'h0;
    logic [3:0]      spi_oe = 4'h0;
    logic            sda_low = 1'b0;
    logic            scl_low = 1'b0;
    logic            sci_tx = 1'b1;
    logic            ir_tx = 1'b0;
    logic            pull_en;
    logic [31:0]     rd;
    logic [7:0]      lat;
    logic [7:0]      dir;
    logic [7:0]      eo;
    logic [5:0]      p;
    int              err_total = 0;
    int              compares = 0;
    int              cycles = 0;

    initial begin
        forever #2 sys_clk = ~sys_clk;
    end

    tpg_gpio i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .port_a_in(pin_x[0]), .port_a_out(out_x[0]), .port_a_oe(oe_x[0]),
        .port_a_led_sink(led), .port_a_analog_sel(ana), .port_b_in(pin_x[1]),
        .port_b_out(out_x[1]), .port_b_oe(oe_x[1]), .port_c_in(pin_x[2]),
        .port_c_out(out_x[2]), .port_c_oe(oe_x[2]), .port_c0_pullup_en(pull_en),
        .iic_sda_pull_low(sda_low), .iic_scl_pull_low(scl_low), .iic_sda_in(), .iic_scl_in(),
        .sci_txd(sci_tx), .sci_rxd(), .tmr_ch_out(tmr_out), .tmr_ch_oe(tmr_oe),
        .tmr_ch_in(), .spi_out(spi_out), .spi_oe(spi_oe), .spi_in(),
        .infrared_transmit_line(ir_tx), .infrared_receive_line(),
        .second_external_interrupt());

    tpg_pin_model i_pins (.drv_level(out_x), .drv_en(oe_x), .outside_level(ext_x),
        .pin_level(pin_x));

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // the request stands until the edge that sees waitrequest low
    // waitrequest and read data are looked at mid-cycle, where they are settled
    task bus(input logic wr, input logic [5:0] idx, input logic [7:0] d);
        logic w;
        @(posedge sys_clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(negedge sys_clk);
            w = avs_waitrequest;
            rd = avs_readdata;
            @(posedge sys_clk);
        end while (w !== 1'b0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task rchk(input logic [5:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(rd[7:0], exp);
    endtask

    // pin outputs move one edge after the write completes
    task settle;
        @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    task give_verdict;
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            give_verdict;
        end
    end

    initial begin
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (p = 4; p < 8; p++) begin
            rchk(p, 8'h00); // directions and led enables start clear
        end
        rchk(6'h03, 8'h00);
        $display("test reset and unmapped done");
        // ****************************************************************
        // latch, direction and read selection on every port
        // ****************************************************************
        for (p = 0; p < 3; p++) begin
            for (int k = 0; k < 2; k++) begin
                lat = (k == 0) ? 8'hA5 : 8'h3C;
                dir = (k == 0) ? 8'h0F : 8'hC3;
                // latch first, then outputs incl. port C pins 0 and 1
                bus(1'b1, p, lat);
                bus(1'b1, p + 6'h04, dir);
                settle;
                rchk(p + 6'h04, dir);
                rchk(p, (lat & dir) | (8'h96 & ~dir));
                eo = (p == 1) ? {dir[7:4], dir[3:0] & ~lat[3:0]} : dir;
                chk(oe_x[p], eo);
                chk(out_x[p], (p == 1) ? {lat[7:4], 4'h0} : lat);
                bus(1'b1, p, ~lat);
                rchk(p, (~lat & dir) | (8'h96 & ~dir));
            end
        end
        $display("test ports done");
        bus(1'b1, 6'h07, 8'hFF);
        rchk(6'h07, 8'hFF);
        settle;
        chk(led, 8'hC3);
        bus(1'b1, 6'h09, 8'h01);
        settle;
        chk(ana, 8'h02);
        chk(oe_x[0], 8'hC1);
        chk(led, 8'hC1);
        $display("test led and converter done");
        @(posedge sys_clk);
        tmr_out <= 4'hF;
        scl_low <= 1'b1;
        tmr_oe <= 4'h2;
        spi_out <= 4'hA;
        spi_oe <= 4'h6;
        sda_low <= 1'b1;
        sci_tx <= 1'b0;
        ir_tx <= 1'b1;
        bus(1'b1, 6'h0A, 8'h0C);
        bus(1'b1, 6'h08, 8'h1F);
        settle;
        chk(oe_x[1], 8'hE7);
        chk(out_x[1], 8'hE0);
        chk(oe_x[2], 8'h5B);
        chk({1'b0, out_x[2][6:0]}, 8'h6B);
        chk({7'h00, pull_en}, 8'h00);
        // release the data line and let the outside raise B0 and B3
        @(posedge sys_clk);
        sda_low <= 1'b0;
        ext_x[1] <= 8'h9F;
        settle;
        chk(oe_x[1], 8'hE6);
        rchk(6'h01, 8'hFB);
        $display("test peripheral takeover done");
        // a reset in mid-run clears directions but keeps latches
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        rchk(6'h06, 8'h00);
        bus(1'b1, 6'h06, 8'hFF);
        rchk(6'h02, 8'hC3);
        $display("test reset keeps latches done");
        give_verdict;
    end
endmodule

bind tpg_gpio tpg_gpio_checker i_chk (.sys_clk(sys_clk), .reset_n(reset_n),
    .port_a_oe(port_a_oe), .port_a_led_sink(port_a_led_sink),
    .port_a_analog_sel(port_a_analog_sel), .port_b_in(port_b_in), .port_b_out(port_b_out),
    .port_c_in(port_c_in), .iic_sda_in(iic_sda_in), .iic_scl_in(iic_scl_in),
    .sci_rxd(sci_rxd), .tmr_ch_in(tmr_ch_in),
    .spi_in(spi_in), .infrared_receive_line(infrared_receive_line),
    .second_external_interrupt(second_external_interrupt));
